// [shared/rtcts_pkg.sv]
// constants and types shared by the rtc timer and serial slave
package rtcts_pkg;
  // register word addresses
  localparam logic [3:0] ADDR_CS1 = 4'h0;
  localparam logic [3:0] ADDR_CS2 = 4'h1;
  localparam logic [3:0] ADDR_SEC = 4'h2;
  localparam logic [3:0] ADDR_TCTL = 4'he;
  localparam logic [3:0] ADDR_TCNT = 4'hf;
  // field positions
  localparam int BIT_TEST = 7;
  localparam int BIT_STOP = 5;
  localparam int BIT_PERMIT = 3;
  localparam int BIT_TFLAG = 2;
  localparam int BIT_TE = 7;
  // implemented bits and reset values
  localparam logic [7:0] CS1_MASK = 8'ha8;
  localparam logic [7:0] CS1_RST = 8'h08;
  localparam logic [7:0] TCTL_MASK = 8'h83;
  localparam logic [7:0] TCTL_RST = 8'h03;
  // timer source select codes
  localparam logic [1:0] SRC_4096 = 2'h0;
  localparam logic [1:0] SRC_64 = 2'h1;
  localparam logic [1:0] SRC_1 = 2'h2;
  localparam logic [1:0] SRC_MIN = 2'h3;
  // tick rates and counts
  localparam int TICK_HZ = 4096;
  localparam logic [5:0] C64_LAST = 6'h3f;
  localparam logic [5:0] SEC_LAST = 6'h3b;
  localparam logic [2:0] OVR_EDGES = 3'h4;
  // serial slave states
  typedef enum {ST_IDLE, ST_RX, ST_RXACK, ST_TX, ST_TXACK} rtcts_st_t;
  typedef enum {PH_ADDR, PH_WORD, PH_DATA} rtcts_ph_t;
endpackage : rtcts_pkg

// [shared/rtcts_reg_if.sv]
// register access path between the serial slave and the register file
`timescale 1ns/1ps
interface rtcts_reg_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] rdata;
  modport bus (output addr, output wdata, output wr, input rdata);
  modport regs (input addr, input wdata, input wr, output rdata);
endinterface : rtcts_reg_if

// [rtl/rtcts_prescaler.sv]
// six-stage prescaler turning the 64 Hz tick into seconds
`timescale 1ns/1ps
module rtcts_prescaler
  import rtcts_pkg::*;
#(
  parameter int W = 6
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic halt,
  input wire logic tick,
  // seconds pulse
  output logic sec_tick
);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic sec_r, sec_nxt;
  localparam logic [W-1:0] HALF_M1 = W'((1 << (W - 1)) - 1);

  // count ticks, cleared while halted
  always_comb begin
    cnt_nxt = cnt_r;
    sec_nxt = 1'b0;
    if (halt) begin
      cnt_nxt = '0; // [RQ10]
    end else if (tick) begin
      cnt_nxt = cnt_r + 1'b1; // [RQ9]
      sec_nxt = (cnt_r == HALF_M1); // [RQ11]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r <= '0;
      sec_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      sec_r <= sec_nxt;
    end
  end

  assign sec_tick = sec_r;

  property p_halt;
    @(posedge clock) disable iff (rst) halt |=> cnt_r == '0;
  endproperty
  a_halt: assert property (p_halt) else $error("prescaler not held at zero"); // [RQ10]

  property p_first;
    @(posedge clock) disable iff (rst) $fell(halt) ##0 (!tick)[*2] |-> !sec_r ##1 !sec_r;
  endproperty
  a_first: assert property (p_first) else $error("seconds pulse without edges"); // [RQ11]

  property p_period;
    @(posedge clock) disable iff (rst) sec_r |-> $past(cnt_r) == HALF_M1;
  endproperty
  a_period: assert property (p_period) else $error("seconds pulse at wrong count"); // [RQ11]
endmodule : rtcts_prescaler

// [rtl/rtcts_i2c_slave.sv]
// two-wire serial bus slave with auto-incrementing word pointer
`timescale 1ns/1ps
module rtcts_i2c_slave
  import rtcts_pkg::*;
#(
  parameter logic [6:0] SLV_ADDR = 7'h2a
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // synchronised bus lines
  input wire logic scl,
  input wire logic sda,
  // data line enable, low pulls the line low
  output logic sda_oe_n,
  // register access
  rtcts_reg_if.bus rb
);
  rtcts_st_t st_r, st_nxt;
  rtcts_ph_t ph_r, ph_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [3:0] bits_r, bits_nxt, ptr_r, ptr_nxt;
  logic rw_r, rw_nxt, oe_n_r, oe_n_nxt, scl_d_r, sda_d_r;
  logic rise, fall, start, stop, byte_done;

  // line events; data moving while clock high is a control condition
  assign rise = scl & ~scl_d_r;
  assign fall = ~scl & scl_d_r;
  assign start = scl & scl_d_r & sda_d_r & ~sda; // [RQ15] [RQ16]
  assign stop = scl & scl_d_r & ~sda_d_r & sda; // [RQ15]
  assign byte_done = (st_r == ST_RX) && fall && (bits_r == 4'h8); // [RQ17]
  assign rb.wr = byte_done && (ph_r == PH_DATA);
  assign rb.addr = ptr_r;
  assign rb.wdata = sh_r;

  // byte, acknowledge and pointer sequencing
  always_comb begin
    st_nxt = st_r;
    ph_nxt = ph_r;
    sh_nxt = sh_r;
    bits_nxt = bits_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    oe_n_nxt = oe_n_r;
    if (start) begin
      st_nxt = ST_RX;
      ph_nxt = PH_ADDR;
      bits_nxt = 4'h0;
      oe_n_nxt = 1'b1;
    end else if (stop) begin
      st_nxt = ST_IDLE;
      oe_n_nxt = 1'b1;
    end else begin
      case (st_r)
        ST_RX: begin
          if (rise) begin
            sh_nxt = {sh_r[6:0], sda};
            bits_nxt = bits_r + 4'h1;
          end else if (byte_done) begin
            bits_nxt = 4'h0;
            if (ph_r == PH_ADDR && sh_r[7:1] != SLV_ADDR) begin
              st_nxt = ST_IDLE;
            end else begin
              oe_n_nxt = 1'b0; // [RQ18]
              st_nxt = ST_RXACK;
              if (ph_r == PH_ADDR) rw_nxt = sh_r[0];
              if (ph_r == PH_WORD) ptr_nxt = sh_r[3:0]; // [RQ21]
              if (ph_r == PH_DATA) ptr_nxt = ptr_r + 4'h1; // [RQ22]
            end
          end
        end
        ST_RXACK: begin
          if (fall) begin
            if (ph_r == PH_ADDR && rw_r) begin
              sh_nxt = rb.rdata;
              oe_n_nxt = rb.rdata[7];
              st_nxt = ST_TX;
            end else begin
              oe_n_nxt = 1'b1;
              st_nxt = ST_RX;
              ph_nxt = (ph_r == PH_ADDR) ? PH_WORD : PH_DATA;
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            if (bits_r == 4'h7) begin
              oe_n_nxt = 1'b1;
              bits_nxt = 4'h0;
              ptr_nxt = ptr_r + 4'h1; // [RQ22]
              st_nxt = ST_TXACK;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_n_nxt = sh_r[6];
              bits_nxt = bits_r + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (rise && sda) begin
            st_nxt = ST_IDLE; // [RQ19]
          end else if (fall) begin
            sh_nxt = rb.rdata;
            oe_n_nxt = rb.rdata[7];
            st_nxt = ST_TX;
          end
        end
        default: st_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= ST_IDLE;
      ph_r <= PH_ADDR;
      sh_r <= 8'h00;
      bits_r <= 4'h0;
      ptr_r <= 4'h0;
      rw_r <= 1'b0;
      oe_n_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      sh_r <= sh_nxt;
      bits_r <= bits_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      oe_n_r <= oe_n_nxt;
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end

  assign sda_oe_n = oe_n_r; // [RQ20]

  property p_ack;
    @(posedge clock) disable iff (rst) byte_done && ph_r != PH_ADDR && !start && !stop |=> !oe_n_r;
  endproperty
  a_ack: assert property (p_ack) else $error("received byte not acknowledged"); // [RQ18]

  property p_inc;
    @(posedge clock) disable iff (rst) rb.wr && !start && !stop |=> ptr_r == $past(ptr_r) + 4'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("word pointer did not advance"); // [RQ22]

  property p_nack;
    @(posedge clock) disable iff (rst) st_r == ST_TXACK && rise && sda && !stop |=> st_r == ST_IDLE && oe_n_r;
  endproperty
  a_nack: assert property (p_nack) else $error("line not released after last byte"); // [RQ19]
endmodule : rtcts_i2c_slave

// [rtl/rtcts_top.sv]
// rtc countdown timer, external clock test mode and serial slave
`timescale 1ns/1ps
// Overview of operation
// [RQ1] eight-bit timer decrements once per source tick
// [RQ2] timer counts only while run-enable bit set
// [RQ3] source select picks 4096, 64, 1, 1/60 Hz
// [RQ4] software parks select at slowest when idle
// [RQ5] countdown register holds loaded count n
// [RQ6] master clocks bus at twice timer source
// [RQ7] test select turns clock pin into input
// [RQ8] test mode: pin edges replace 64 Hz tick
// [RQ9] six-stage prescaler makes seconds from 64 Hz
// [RQ10] halt bit holds prescaler at zero
// [RQ11] first second after 32 edges, then 64
// [RQ12] prescaler state undefined on test entry
// [RQ13] toggle sequence ends power-on reset at once
// [RQ14] permit bit zero ends and blocks override
// [RQ15] start and stop are data edges, clock high
// [RQ16] data changes only while clock is low
// [RQ17] each byte followed by one acknowledge slot
// [RQ18] slave receiver acknowledges every received byte
// [RQ19] master nacks last byte, slave releases line
// [RQ20] slave only; clock input, data open drain
// [RQ21] only low four word address bits used
// [RQ22] word address increments after each data byte
// [RQ23] expiry sets flag, reloads count, continues
module rtcts_top
  import rtcts_pkg::*;
#(
  parameter int CLK_HZ = 100_000_000,
  parameter int DIV4096 = CLK_HZ / TICK_HZ,
  parameter int POR_CYCLES = 1000,
  parameter logic [6:0] SLV_ADDR = 7'h2a
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // serial bus pins
  input wire logic scl,
  input wire logic sda_line,
  output logic sda_drive,
  output logic sda_oe_n,
  // clock output pin
  input wire logic clock_output_pin,
  output logic clock_output_pin_drive,
  output logic clock_output_pin_oe_n,
  // status
  output logic timer_flag
);
  localparam int DW = $clog2(DIV4096);
  localparam int PW = $clog2(POR_CYCLES + 1);

  //--------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------
  logic [2:0] meta_r, sync_r, prev_r;
  logic scl_s, sda_s, pin_rise, sda_edge;

  // two flops on {clock pin, data, clock}, then one history stage
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_r <= 3'h7;
      sync_r <= 3'h7;
      prev_r <= 3'h7;
    end else begin
      meta_r <= {clock_output_pin, sda_line, scl};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign scl_s = sync_r[0];
  assign sda_s = sync_r[1];
  assign sda_edge = sync_r[1] ^ prev_r[1];
  assign pin_rise = sync_r[2] & ~prev_r[2];

  //--------------------------------------------------
  // power-on reset and override
  //--------------------------------------------------
  logic por_r, por_nxt, ovr_r, ovr_nxt, ovr_go, core_rst;
  logic [PW-1:0] por_cnt_r, por_cnt_nxt;
  logic [2:0] tog_r, tog_nxt;
  logic [7:0] cs1_r, cs1_nxt;
  rtcts_reg_if rb ();

  // data toggles while clock low are counted while power-on reset lasts; the fourth ends reset only if override is permitted
  assign ovr_go = por_r && cs1_r[BIT_PERMIT] && sda_edge && !scl_s && tog_r == OVR_EDGES - 3'h1;

  always_comb begin
    por_nxt = por_r;
    ovr_nxt = ovr_r;
    por_cnt_nxt = por_cnt_r;
    tog_nxt = tog_r;
    if (por_r) begin
      if (sda_edge && !scl_s) tog_nxt = tog_r + 3'h1;
      if (ovr_go) begin
        por_nxt = 1'b0; // [RQ13]
        ovr_nxt = 1'b1;
      end else if (por_cnt_r == PW'(POR_CYCLES - 1)) begin
        por_nxt = 1'b0;
      end else begin
        por_cnt_nxt = por_cnt_r + 1'b1;
      end
    end
    if (rb.wr && rb.addr == ADDR_CS1 && !rb.wdata[BIT_PERMIT]) ovr_nxt = 1'b0; // [RQ14]
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      por_r <= 1'b1;
      ovr_r <= 1'b0;
      por_cnt_r <= '0;
      tog_r <= 3'h0;
    end else begin
      por_r <= por_nxt;
      ovr_r <= ovr_nxt;
      por_cnt_r <= por_cnt_nxt;
      tog_r <= tog_nxt;
    end
  end

  // bus held off until power-on reset ends
  assign core_rst = rst | por_r;

  //--------------------------------------------------
  // serial slave
  //--------------------------------------------------
  rtcts_i2c_slave #(
    .SLV_ADDR(SLV_ADDR)
  ) u_slave (
    .clock(clock),
    .rst(core_rst),
    .scl(scl_s),
    .sda(sda_s),
    .sda_oe_n(sda_oe_n),
    .rb(rb.bus)
  );

  //--------------------------------------------------
  // tick generation
  //--------------------------------------------------
  logic [DW-1:0] div_r, div_nxt;
  logic [5:0] c64_r, c64_nxt;
  logic t4096, t64_int, t64, sec_tick, min_tick, test_on;

  assign test_on = cs1_r[BIT_TEST];
  assign t4096 = (div_r == DW'(DIV4096 - 1));
  assign t64_int = t4096 && (c64_r == C64_LAST);
  // test mode takes pin edges in place of the internal 64 Hz tick
  assign t64 = test_on ? pin_rise : t64_int; // [RQ8] [RQ12]

  always_comb begin
    div_nxt = t4096 ? '0 : div_r + 1'b1;
    c64_nxt = t4096 ? c64_r + 6'h1 : c64_r;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      div_r <= '0;
      c64_r <= 6'h00;
    end else begin
      div_r <= div_nxt;
      c64_r <= c64_nxt;
    end
  end

  rtcts_prescaler u_pre (
    .clock(clock),
    .rst(core_rst),
    .halt(cs1_r[BIT_STOP]),
    .tick(t64),
    .sec_tick(sec_tick)
  );

  //--------------------------------------------------
  // register file and countdown timer
  //--------------------------------------------------
  logic [7:0] tctl_r, tctl_nxt, tload_r, tload_nxt, tcnt_r, tcnt_nxt;
  logic [5:0] sec_r, sec_nxt;
  logic flag_r, flag_nxt, flag_set, flag_clr, tmr_tick, tcnt_wr, te;

  assign te = tctl_r[BIT_TE];
  assign tcnt_wr = rb.wr && rb.addr == ADDR_TCNT;
  assign min_tick = sec_tick && sec_r == SEC_LAST;

  // source select
  always_comb begin
    case (tctl_r[1:0])
      SRC_4096: tmr_tick = t4096; // [RQ3]
      SRC_64: tmr_tick = t64;
      SRC_1: tmr_tick = sec_tick;
      SRC_MIN: tmr_tick = min_tick;
      default: tmr_tick = 1'b0;
    endcase
  end

  // register writes, seconds count and timer countdown
  always_comb begin
    cs1_nxt = cs1_r;
    tctl_nxt = tctl_r;
    tload_nxt = tload_r;
    tcnt_nxt = tcnt_r;
    sec_nxt = sec_r;
    flag_set = 1'b0;
    flag_clr = 1'b0;
    if (sec_tick) sec_nxt = (sec_r == SEC_LAST) ? 6'h00 : sec_r + 6'h1;
    if (tmr_tick && te && !tcnt_wr) begin // [RQ2]
      if (tcnt_r <= 8'h01) begin
        tcnt_nxt = tload_r; // [RQ23]
        flag_set = 1'b1;
      end else begin
        tcnt_nxt = tcnt_r - 8'h01; // [RQ1]
      end
    end
    if (rb.wr) begin
      case (rb.addr)
        ADDR_CS1: cs1_nxt = rb.wdata & CS1_MASK; // [RQ7] [RQ10]
        ADDR_CS2: flag_clr = !rb.wdata[BIT_TFLAG];
        ADDR_SEC: sec_nxt = rb.wdata[5:0];
        ADDR_TCTL: tctl_nxt = rb.wdata & TCTL_MASK;
        ADDR_TCNT: begin
          tload_nxt = rb.wdata; // [RQ5]
          tcnt_nxt = rb.wdata;
        end
        default: ;
      endcase
    end
    // a fresh expiry wins over a clear in the same cycle
    flag_nxt = flag_set | (flag_r & ~flag_clr);
  end

  always_ff @(posedge clock) begin
    if (core_rst) begin
      cs1_r <= CS1_RST;
      tctl_r <= TCTL_RST;
      tload_r <= 8'h00;
      tcnt_r <= 8'h00;
      sec_r <= 6'h00;
      flag_r <= 1'b0;
    end else begin
      cs1_r <= cs1_nxt;
      tctl_r <= tctl_nxt;
      tload_r <= tload_nxt;
      tcnt_r <= tcnt_nxt;
      sec_r <= sec_nxt;
      flag_r <= flag_nxt;
    end
  end

  // read mux, live countdown value on its own address
  always_comb begin
    case (rb.addr)
      ADDR_CS1: rb.rdata = cs1_r;
      ADDR_CS2: rb.rdata = {5'h00, flag_r, 2'h0};
      ADDR_SEC: rb.rdata = {2'h0, sec_r};
      ADDR_TCTL: rb.rdata = tctl_r;
      ADDR_TCNT: rb.rdata = tcnt_r;
      default: rb.rdata = 8'h00;
    endcase
  end

  //--------------------------------------------------
  // output flops
  //--------------------------------------------------
  logic pin_out_r, pin_out_nxt, pin_oe_n_r, pin_oe_n_nxt, flag_out_r;

  // clock pin drives a square wave unless test mode makes it an input
  always_comb begin
    pin_out_nxt = t64_int ? ~pin_out_r : pin_out_r;
    pin_oe_n_nxt = test_on; // [RQ7]
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_out_r <= 1'b0;
      pin_oe_n_r <= 1'b1;
      flag_out_r <= 1'b0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
      flag_out_r <= flag_nxt;
    end
  end

  assign sda_drive = 1'b0; // open drain, only the enable moves
  assign clock_output_pin_drive = pin_out_r;
  assign clock_output_pin_oe_n = pin_oe_n_r;
  assign timer_flag = flag_out_r;

  //--------------------------------------------------
  // checks
  //--------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (core_rst);

  sequence s_run;
    tmr_tick && te && !tcnt_wr;
  endsequence

  property p_dec;
    s_run ##0 tcnt_r > 8'h01 |=> tcnt_r == $past(tcnt_r) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("timer did not decrement"); // [RQ1]

  property p_stop;
    !te && !tcnt_wr |=> tcnt_r == $past(tcnt_r);
  endproperty
  a_stop: assert property (p_stop) else $error("timer moved while disabled"); // [RQ2]

  property p_src;
    tctl_r[1:0] == SRC_4096 && t4096 && te && !tcnt_wr && tcnt_r > 8'h01 |=> tcnt_r != $past(tcnt_r);
  endproperty
  a_src: assert property (p_src) else $error("fast source tick missed"); // [RQ3]

  property p_reload;
    s_run ##0 tcnt_r <= 8'h01 |=> flag_r && timer_flag && tcnt_r == tload_r;
  endproperty
  a_reload: assert property (p_reload) else $error("timer did not reload and flag"); // [RQ23]

  property p_test_in;
    test_on |=> clock_output_pin_oe_n;
  endproperty
  a_test_in: assert property (p_test_in) else $error("clock pin still driven in test"); // [RQ7]

  property p_ext;
    test_on && pin_rise && !cs1_r[BIT_STOP] |=> u_pre.cnt_r == $past(u_pre.cnt_r) + 6'h1;
  endproperty
  a_ext: assert property (p_ext) else $error("pin edge not used as tick"); // [RQ8]

  property p_override;
    @(posedge clock) disable iff (rst) ovr_go |=> !por_r && ovr_r;
  endproperty
  a_override: assert property (p_override) else $error("override did not end reset"); // [RQ13]

  property p_permit;
    @(posedge clock) disable iff (rst) rb.wr && rb.addr == ADDR_CS1 && !rb.wdata[BIT_PERMIT] |=> !ovr_r;
  endproperty
  a_permit: assert property (p_permit) else $error("override not cleared"); // [RQ14]
endmodule : rtcts_top

// [tb/rtcts_master_bfm.sv]
// two-wire bus master model facing the serial slave
`timescale 1ns/1ps
module rtcts_master_bfm #(
  parameter logic [6:0] SLV = 7'h2a,
  parameter int H = 8
) (
  // clock
  input wire logic clock,
  // bus lines, enable low pulls data low
  output logic scl,
  output logic sda_oe_n,
  input wire logic sda_line
);
  // ----------------------------------------
  // line control
  // ----------------------------------------
  // both lines idle high
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end

  // wait a number of clock edges
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask : hold

  // start or repeated start, data falls while clock high
  task automatic start_c();
    sda_oe_n <= 1'b1;
    hold(H);
    scl <= 1'b1;
    hold(H);
    sda_oe_n <= 1'b0;
    hold(H);
    scl <= 1'b0;
    hold(2);
  endtask : start_c

  // stop, data rises while clock high
  task automatic stop_c();
    sda_oe_n <= 1'b0;
    hold(H);
    scl <= 1'b1;
    hold(H);
    sda_oe_n <= 1'b1;
    hold(H);
  endtask : stop_c

  // data toggles with the clock held low, for the reset override
  task automatic toggle(input int n);
    scl <= 1'b0;
    hold(4);
    repeat (n) begin
      sda_oe_n <= ~sda_oe_n;
      hold(2);
    end
    hold(4);
    scl <= 1'b1;
    hold(4);
  endtask : toggle

  // one bit slot, data changed only while clock low
  task automatic bit_x(input logic b, output logic r);
    sda_oe_n <= b;
    hold(H);
    scl <= 1'b1;
    hold(H);
    r = sda_line;
    scl <= 1'b0;
    hold(2);
  endtask : bit_x

  // ----------------------------------------
  // byte and register transfers
  // ----------------------------------------
  // eight bits msb first then the acknowledge slot
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, ack);
  endtask : wbyte

  // read eight bits, then ack or leave unacknowledged
  task automatic rbyte(input logic nack, output logic [7:0] b, output logic seen);
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(nack, seen);
  endtask : rbyte

  // write one register
  task automatic write_reg(input logic [7:0] word, input logic [7:0] d, output logic [2:0] acks);
    start_c();
    wbyte({SLV, 1'b0}, acks[2]);
    wbyte(word, acks[1]);
    wbyte(d, acks[0]);
    stop_c();
  endtask : write_reg

  // read two registers, last byte unacknowledged
  task automatic read_reg(input logic [7:0] word, output logic [7:0] d0, output logic [7:0] d1,
                          output logic [3:0] acks);
    logic s;
    start_c();
    wbyte({SLV, 1'b0}, acks[3]);
    wbyte(word, acks[2]);
    start_c();
    wbyte({SLV, 1'b1}, acks[1]);
    rbyte(1'b0, d0, s);
    rbyte(1'b1, d1, acks[0]);
    stop_c();
  endtask : read_reg
endmodule : rtcts_master_bfm

// [tb/tb.sv]
// self-checking bench for the rtc timer, test mode and serial slave
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
  import rtcts_pkg::*;
  localparam int DIVTB = 4;
  localparam logic [6:0] SLV = 7'h2a;
  logic clock;
  logic rst;
  logic ext_pin;
  logic pin_wire;
  logic m_scl;
  logic m_oe_n;
  logic sda_oe_n;
  logic sda_drive;
  logic sda_line;
  logic pin_drive;
  logic pin_oe_n;
  logic timer_flag;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;

  // wired data line with pull-up, clock pin from whichever side drives
  assign sda_line = m_oe_n & (sda_oe_n ? 1'b1 : sda_drive);
  assign pin_wire = pin_oe_n ? ext_pin : pin_drive;

  // clock and cycle count
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  rtcts_top #(.DIV4096(DIVTB), .POR_CYCLES(200), .SLV_ADDR(SLV)) dut (
    .clock(clock), .rst(rst), .scl(m_scl), .sda_line(sda_line), .sda_drive(sda_drive),
    .sda_oe_n(sda_oe_n), .clock_output_pin(pin_wire), .clock_output_pin_drive(pin_drive),
    .clock_output_pin_oe_n(pin_oe_n), .timer_flag(timer_flag));
  rtcts_master_bfm #(.SLV(SLV)) master (.clock(clock), .scl(m_scl), .sda_oe_n(m_oe_n), .sda_line(sda_line));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // register write, upper word nibble set to junk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [2:0] acks;
    master.write_reg({4'ha, a}, d, acks);
    `CHK(acks, 3'b000)
  endtask : wr

  // two-register read
  task automatic rd(input logic [3:0] a, output logic [7:0] d0, output logic [7:0] d1);
    logic [3:0] acks;
    master.read_reg({4'h5, a}, d0, d1, acks);
    `CHK(acks, 4'b0001)
  endtask : rd

  // bounded wait for the timer flag, returns the cycle seen
  task automatic wait_flag(input int lim, output int t);
    int n;
    n = 0;
    while (timer_flag !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      end_sim();
    end
    t = cyc;
  endtask : wait_flag

  // rising edges on the clock pin
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge clock);
      ext_pin <= 1'b1;
      repeat (4) @(posedge clock);
      ext_pin <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask : pulse

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] d0;
    logic [7:0] d1;
    rd(ADDR_TCNT, d0, d1);
    `CHK(d1, CS1_RST)
    rd(ADDR_TCTL, d0, d1);
    `CHK(d0, TCTL_RST)
  endtask : t_reset

  // burst write of two registers, timer stopped keeps its count
  task automatic t_regs();
    logic [7:0] d0;
    logic [7:0] d1;
    logic [2:0] a;
    logic a0;
    master.start_c();
    master.wbyte({SLV, 1'b0}, a[2]);
    master.wbyte({4'hf, ADDR_TCTL}, a[1]);
    master.wbyte(8'h01, a[0]);
    master.wbyte(8'h07, a0);
    master.stop_c();
    `CHK({a, a0}, 4'h0)
    rd(ADDR_TCTL, d0, d1);
    `CHK(d0, 8'h01)
    `CHK(d1, 8'h07)
  endtask : t_regs

  // wrong slave address is not acknowledged
  task automatic t_refuse();
    logic ack;
    master.start_c();
    master.wbyte({SLV ^ 7'h01, 1'b0}, ack);
    master.stop_c();
    `CHK(ack, 1'b1)
  endtask : t_refuse

  // flag period for the 4096, 64 and 1 Hz sources, reload after expiry
  task automatic t_timer();
    logic [1:0] src [3] = '{SRC_4096, SRC_64, SRC_1};
    logic [7:0] cnt [3] = '{8'hff, 8'h03, 8'h01};
    int per [3] = '{1, 64, 4096};
    int t0;
    int t1;
    int lim;
    for (int i = 0; i < 3; i++) begin
      lim = 2 * int'(cnt[i]) * per[i] * DIVTB + 4000;
      wr(ADDR_TCTL, {6'h00, src[i]});
      wr(ADDR_TCNT, cnt[i]);
      wr(ADDR_CS2, 8'h00);
      wr(ADDR_TCTL, {1'b1, 5'h00, src[i]});
      wait_flag(lim, t0);
      wr(ADDR_CS2, 8'h00);
      `CHK(timer_flag, 1'b0)
      wait_flag(lim, t1);
      `CHK(t1 - t0, int'(cnt[i]) * per[i] * DIVTB)
    end
    wr(ADDR_TCTL, {6'h00, SRC_MIN});
  endtask : t_timer

  // external clock test mode with prescaler halt
  task automatic t_test();
    int edges [4] = '{31, 1, 63, 1};
    logic [7:0] secs [4] = '{8'h00, 8'h01, 8'h01, 8'h02};
    logic [7:0] d0;
    logic [7:0] d1;
    logic v;
    int n;
    `CHK(pin_oe_n, 1'b0)
    // pin square wave flips once per internal 64 Hz tick
    for (int k = 0; k < 2; k++) begin
      v = pin_drive;
      n = 0;
      while (pin_drive === v && n < 600) begin
        @(negedge clock);
        n++;
      end
    end
    `CHK(n, 64 * DIVTB)
    wr(ADDR_CS1, 8'h88);
    `CHK(pin_oe_n, 1'b1)
    wr(ADDR_CS1, 8'ha8);
    pulse(10);
    wr(ADDR_CS1, 8'h88);
    wr(ADDR_SEC, 8'h00);
    for (int i = 0; i < 4; i++) begin
      pulse(edges[i]);
      rd(ADDR_SEC, d0, d1);
      `CHK(d0, secs[i])
    end
    // per-minute source: seconds 59 to 0 gives the only tick
    wr(ADDR_TCNT, 8'h01);
    wr(ADDR_TCTL, {1'b1, 5'h00, SRC_MIN});
    wr(ADDR_CS2, 8'h00);
    wr(ADDR_SEC, 8'h3a);
    pulse(64);
    `CHK(timer_flag, 1'b0)
    pulse(64);
    `CHK(timer_flag, 1'b1)
  endtask : t_test

  // override sequence ends power-on reset early after a mid-run reset
  task automatic t_override();
    logic [7:0] d0;
    logic [7:0] d1;
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    `CHK(sda_oe_n, 1'b1)
    rst <= 1'b0;
    master.toggle(4);
    rd(ADDR_CS1, d0, d1);
    `CHK(d0, CS1_RST)
  endtask : t_override

  // main sequence
  initial begin
    rst = 1'b1;
    ext_pin = 1'b0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (210) @(posedge clock);
    t_reset();
    t_regs();
    t_refuse();
    t_timer();
    t_test();
    t_override();
    end_sim();
  end
endmodule : tb
